/* File: src/wwd_pkg.sv */
/*
 * Constants, field layout and types for the windowed watchdog unit.
 * Assumes a single 200 MHz bus clock; the watchdog time base is a tick enable.
 */
`default_nettype none

package wwd_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CLEAR_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0C;
    // control field positions
    localparam int EN_BIT = 0;
    localparam int MODE_BIT = 1;
    localparam int PSEL_LSB = 8;
    localparam int BAN_SEL_LSB = 16;
    localparam int PSEL_W = 5;
    localparam int CLEAR_BIT = 0;
    // status field positions
    localparam int RSTF_BIT = 0;
    localparam int EARLY_BIT = 1;
    localparam int BAN_BIT = 2;
    // reset values
    localparam logic [4:0] PSEL_RST = 5'h04;
    localparam logic [4:0] BAN_SEL_RST = 5'h02;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int RST_HOLD_NS = 100;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_BUS_CYC = 2;
    localparam int SYNC_WD_TICKS = 2;
    localparam int TICK_DIV_DEF = 4;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SYNC_IDLE, SYNC_BUS, SYNC_WD} wwd_sync_state_t;
endpackage

`default_nettype wire

/* File: src/wwd_sync.sv */
/*
 * Control-field transfer timer: waits bus cycles, then watchdog ticks.
 * Assumes start is a one-cycle pulse and tick a one-cycle enable.
 */
`default_nettype none

module wwd_sync
    import wwd_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // handshake
    wwd_sync_if.syn s
);
    wwd_sync_state_t state;
    logic [1:0] cnt;

    // a fresh start always restarts the wait, so the last value written wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= SYNC_IDLE;
            cnt <= 2'h0;
            s.done <= 1'b0;
        end
        else
        begin
            s.done <= 1'b0;
            if (s.start)
            begin
                state <= SYNC_BUS;
                cnt <= 2'h0;
            end
            else
            begin
                unique case (state)
                    SYNC_IDLE: cnt <= 2'h0;
                    SYNC_BUS:
                    begin
                        if (cnt == 2'(SYNC_BUS_CYC - 1))
                        begin
                            state <= SYNC_WD;
                            cnt <= 2'h0;
                        end
                        else
                            cnt <= cnt + 2'h1;
                    end
                    SYNC_WD:
                    begin
                        if (s.tick && cnt == 2'(SYNC_WD_TICKS - 1))
                        begin
                            state <= SYNC_IDLE;
                            s.done <= 1'b1;
                        end
                        else if (s.tick)
                            cnt <= cnt + 2'h1;
                    end
                endcase
            end
        end
    end

    assign s.busy = (state != SYNC_IDLE);

    a_sync_min_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        s.start |=> !s.done [*2])
        else $error("transfer finished too early");
endmodule

`default_nettype wire

/* File: src/wwd_sync_if.sv */
/*
 * Handshake between the register side and the control-field transfer logic.
 * Assumes both ends run on aclk.
 */
`default_nettype none

interface wwd_sync_if;
    logic start;
    logic tick;
    logic busy;
    logic done;
    modport ctl (output start, output tick, input busy, input done);
    modport syn (input start, input tick, output busy, output done);
endinterface

`default_nettype wire

/* File: src/wwd_top.sv */
/*
 * Windowed watchdog unit with an AXI4-Lite register slave.
 * Assumes one aclk; the watchdog time base is a divided tick enable.
 */
`default_nettype none

module wwd_top
    import wwd_pkg::*;
#(
    parameter int TICK_DIV = TICK_DIV_DEF
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // watchdog reset request
    output logic wd_reset
);
    wwd_sync_if sif ();

    // bus side state
    logic aw_got;
    logic w_got;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_go;
    logic [31:0] ctrl_new;
    // staged and effective control
    logic st_en;
    logic st_mode;
    logic [4:0] st_psel;
    logic [4:0] st_ban_period_prescale_select;
    logic eff_en;
    logic eff_mode;
    logic [4:0] eff_psel;
    logic [4:0] eff_ban_period_prescale_select;
    // watchdog core
    logic [7:0] div_cnt;
    logic [32:0] cnt;
    logic clr_req;
    logic second_half;
    logic in_ban;
    logic early_fire;
    logic ban_fire;
    logic expire;
    logic [7:0] hold_cnt;
    logic [2:0] status;

    wwd_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .s(sif.syn)
    );

    // merge byte lanes of a write into the current control view
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            old_v[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
        return old_v;
    endfunction

    // write address capture; one write in flight at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;
            aw_got <= 1'b0;
            wr_addr <= 8'h00;
        end
        else if (awvalid && awready)
        begin
            awready <= 1'b0;
            aw_got <= 1'b1;
            wr_addr <= awaddr;
        end
        else
        begin
            awready <= awvalid && !aw_got && !bvalid && !awready;
            if (wr_go)
                aw_got <= 1'b0;
        end
    end

    // write data capture, independent of the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready <= 1'b0;
            w_got <= 1'b0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end
        else if (wvalid && wready)
        begin
            wready <= 1'b0;
            w_got <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end
        else
        begin
            wready <= wvalid && !w_got && !bvalid && !wready;
            if (wr_go)
                w_got <= 1'b0;
        end
    end

    assign wr_go = aw_got && w_got && !bvalid;

    // write response; unmapped offsets answer with a slave error
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid <= 1'b1;
            bresp <= (wr_addr == CTRL_OFS || wr_addr == CLEAR_OFS ||
                      wr_addr == STATUS_OFS) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // staged copy of the control fields as software wrote them
    assign ctrl_new = lane_merge({11'h000, st_ban_period_prescale_select, 3'h0, st_psel,
                                 6'h00, st_mode, st_en}, wr_data, wr_strb);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_en <= 1'b0;
            st_mode <= 1'b0;
            st_psel <= PSEL_RST;
            st_ban_period_prescale_select <= BAN_SEL_RST;
            sif.start <= 1'b0;
        end
        else
        begin
            sif.start <= wr_go && wr_addr == CTRL_OFS;
            if (wr_go && wr_addr == CTRL_OFS)
            begin
                st_en <= ctrl_new[EN_BIT];
                st_mode <= ctrl_new[MODE_BIT];
                st_psel <= ctrl_new[PSEL_LSB +: PSEL_W];
                st_ban_period_prescale_select <= ctrl_new[BAN_SEL_LSB +: PSEL_W];
            end
        end
    end

    // effective fields change only when the transfer ends
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            eff_en <= 1'b0;
            eff_mode <= 1'b0;
            eff_psel <= PSEL_RST;
            eff_ban_period_prescale_select <= BAN_SEL_RST;
        end
        else if (sif.done)
        begin
            eff_en <= st_en;
            eff_mode <= st_mode;
            eff_psel <= st_psel;
            eff_ban_period_prescale_select <= st_ban_period_prescale_select;
        end
    end

    // watchdog time base divider
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt <= 8'h00;
            sif.tick <= 1'b0;
        end
        else
        begin
            sif.tick <= (div_cnt == 8'(TICK_DIV - 1));
            div_cnt <= (div_cnt == 8'(TICK_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
        end
    end

    // software clear request, one cycle after the write is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clr_req <= 1'b0;
        else
            clr_req <= wr_go && wr_addr == CLEAR_OFS && wr_strb[0] && wr_data[CLEAR_BIT];
    end

    // period is 2^(psel+1) ticks for psel up to 30, one tick for psel 31; the half mark is 2^psel
    assign second_half = (cnt >> eff_psel) != 33'h0;
    assign in_ban = (cnt >> eff_ban_period_prescale_select) == 33'h0;
    assign early_fire = clr_req && eff_en && second_half;
    assign ban_fire = clr_req && eff_en && eff_mode && in_ban && !second_half;
    assign expire = sif.tick && eff_en &&
                    (cnt == ((33'h1 << (eff_psel + 5'h1)) - 33'h1));

    // counter; a clear restarts from zero whatever else happens
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt <= 33'h0;
        else if (!eff_en || clr_req || expire)
            cnt <= 33'h0;
        else if (sif.tick)
            cnt <= cnt + 33'h1;
    end

    // reset request stretched so a slow reset controller sees it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wd_reset <= 1'b0;
            hold_cnt <= 8'h00;
        end
        else if (early_fire || ban_fire || expire)
        begin
            wd_reset <= 1'b1;
            hold_cnt <= 8'(RST_HOLD_CYC - 1);
        end
        else if (hold_cnt != 8'h00)
            hold_cnt <= hold_cnt - 8'h01;
        else
            wd_reset <= 1'b0;
    end

    // reset cause flags; a new event wins over a write-one clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status <= 3'h0;
        else
        begin
            for (int i = 0; i < 3; i++)
                if (wr_go && wr_addr == STATUS_OFS && wr_strb[0] && wr_data[i])
                    status[i] <= 1'b0;
            if (early_fire || ban_fire || expire)
                status[RSTF_BIT] <= 1'b1;
            if (early_fire)
                status[EARLY_BIT] <= 1'b1;
            if (ban_fire)
                status[BAN_BIT] <= 1'b1;
        end
    end

    // read channel; enable reads back the live value, so polling shows progress
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            unique case (araddr)
                CTRL_OFS: rdata <= {11'h000, st_ban_period_prescale_select, 3'h0, st_psel, 6'h00,
                                    st_mode, eff_en};
                STATUS_OFS: rdata <= {29'h0, status};
                COUNT_OFS: rdata <= cnt[31:0];
                CLEAR_OFS: rdata <= 32'h00000000;
                default:
                begin
                    rdata <= 32'h00000000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end
        else
        begin
            arready <= arvalid && !rvalid && !arready;
            if (rready)
                rvalid <= 1'b0;
        end
    end

    a_early_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_req && eff_en && second_half |=> wd_reset && status[EARLY_BIT])
        else $error("late clear did not fire reset");
    a_timeout_fire: assert property (@(posedge aclk) disable iff (!aresetn)
        expire |=> wd_reset && cnt == 33'h0)
        else $error("timeout did not fire reset");
    a_ctrl_start: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_addr == CTRL_OFS |=> sif.start ##1 sif.busy)
        else $error("control write did not start transfer");
    a_en_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        !sif.done |=> $stable(eff_en))
        else $error("enable changed outside transfer end");
    a_en_update: assert property (@(posedge aclk) disable iff (!aresetn)
        sif.done |=> eff_en == $past(st_en))
        else $error("enable not updated at transfer end");
    a_clear_ok: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_req && !early_fire && !ban_fire && !expire && !wd_reset
        |=> cnt == 33'h0 && !wd_reset)
        else $error("allowed clear misbehaved");
    a_reset_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(wd_reset) |-> wd_reset [*8])
        else $error("reset request too short");
endmodule

`default_nettype wire

/* File: verif/tb.sv */
/*
 * Self-checking bench for the windowed watchdog unit, driven over AXI4-Lite.
 * Assumes the design's package and a tick divider of 4 aclk per watchdog tick.
 */
`default_nettype none

module tb
    import wwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TDIV = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, wd_reset;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;

    wwd_top #(.TICK_DIV(TDIV)) i_wwd_top (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .wd_reset(wd_reset));

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count = check_count + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw_ok)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_ok)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1)
            @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // counts edges until wd_reset is seen high, or the limit
    task automatic wait_rst(input int lim, output int n);
        n = 0;
        while (wd_reset !== 1'b1 && n < lim)
        begin
            @(posedge aclk);
            n = n + 1;
        end
    endtask

    task automatic wait_low();
        int n;
        n = 0;
        while (wd_reset !== 1'b0 && n < 200)
        begin
            @(posedge aclk);
            n = n + 1;
        end
    endtask

    // polls the effective enable bit until it matches, bounded
    task automatic poll_en(input logic v);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        d = ~{32{v}};
        while (d[EN_BIT] !== v && n < 30)
        begin
            axi_read(CTRL_OFS, d, r);
            n = n + 1;
        end
        chk("enable settled", {31'h0, v}, {31'h0, d[EN_BIT]});
    endtask

    initial
    begin
        logic [31:0] d;
        logic [31:0] c;
        logic [1:0] r;
        int n;
        int len;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("wd_reset after reset", 32'h0, {31'h0, wd_reset});
        // unmapped place refuses and leaves control untouched
        axi_write(8'h10, 32'hFFFF_FFFF, r);
        chk("bresp unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_read(8'h10, d, r);
        chk("rresp unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("rdata unmapped", 32'h0, d);
        axi_read(CTRL_OFS, d, r);
        chk("ctrl reset", {11'h0, BAN_SEL_RST, 3'h0, PSEL_RST, 8'h00}, d);
        axi_read(STATUS_OFS, d, r);
        chk("status reset", 32'h0, d);
        // enable: old value read back until the transfer completes
        axi_write(CTRL_OFS, 32'h0000_0401, r);
        chk("bresp ctrl", {30'h0, RESP_OKAY}, {30'h0, r});
        axi_read(CTRL_OFS, d, r);
        chk("rresp ctrl", {30'h0, RESP_OKAY}, {30'h0, r});
        chk("enable old", 32'h0, {31'h0, d[EN_BIT]});
        poll_en(1'b1);
        repeat (40) @(posedge aclk);
        axi_read(COUNT_OFS, c, r);
        chk("counting", 32'h1, {31'h0, c >= 32'h5});
        // clear inside the first half restarts from zero
        axi_write(CLEAR_OFS, 32'h0000_0001, r);
        axi_read(COUNT_OFS, d, r);
        chk("restart", 32'h1, {31'h0, d < c});
        wait_rst(40, n);
        chk("no reset early clear", 32'h0, {31'h0, wd_reset});
        // clear in the second half fires at once
        n = 0;
        d = 32'h0;
        while (d < 32'h10 && n < 60)
        begin
            axi_read(COUNT_OFS, d, r);
            n = n + 1;
        end
        axi_write(CLEAR_OFS, 32'h0000_0001, r);
        wait_rst(6, n);
        chk("late clear reset", 32'h1, {31'h0, wd_reset});
        len = 0;
        while (wd_reset === 1'b1 && len < 100)
        begin
            @(posedge aclk);
            len = len + 1;
        end
        chk("reset hold", RST_HOLD_CYC, len);
        axi_read(STATUS_OFS, d, r);
        chk("late flag", 32'h1, {31'h0, d[EARLY_BIT]});
        axi_write(STATUS_OFS, 32'h0000_0007, r);
        axi_read(STATUS_OFS, d, r);
        chk("status cleared", 32'h0, d);
        // no clear: period of 2^(psel+1) ticks runs out
        axi_write(CLEAR_OFS, 32'h0000_0001, r);
        wait_rst(300, n);
        chk("timeout reset", 32'h1, {31'h0, wd_reset});
        chk("timeout span", 32'h1, {31'h0, n >= 29 * TDIV && n <= 33 * TDIV});
        axi_read(STATUS_OFS, d, r);
        chk("fired flag", 32'h1, {31'h0, d[RSTF_BIT]});
        wait_low();
        axi_write(STATUS_OFS, 32'h0000_0007, r);
        // window mode: clear inside the ban period fires
        axi_write(CTRL_OFS, 32'h0003_0403, r);
        repeat (20) @(posedge aclk);
        axi_write(CLEAR_OFS, 32'h0000_0001, r);
        axi_write(CLEAR_OFS, 32'h0000_0001, r);
        wait_rst(6, n);
        chk("ban clear reset", 32'h1, {31'h0, wd_reset});
        axi_read(STATUS_OFS, d, r);
        chk("ban flag", 32'h1, {31'h0, d[BAN_BIT]});
        wait_low();
        // disable: old enable seen, then the new one
        axi_write(CTRL_OFS, 32'h0003_0400, r);
        axi_read(CTRL_OFS, d, r);
        chk("disable old", 32'h1, {31'h0, d[EN_BIT]});
        poll_en(1'b0);
        axi_read(CTRL_OFS, d, r);
        chk("fields as written", 32'h0003_0400, d & 32'h001F_1F03);
        repeat (20) @(posedge aclk);
        end_of_test();
    end
endmodule

`default_nettype wire
